// ### include/xfer_params.svh
`ifndef XFER_PARAMS_SVH
`define XFER_PARAMS_SVH

// ----------------------------------------
// Register map of the control port
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define CTRL_START 0
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_END 2

// ----------------------------------------
// Descriptor area and slot layout
// ----------------------------------------
`define DESC_LO 16'hf800
`define DESC_HI 16'hfbff
`define DESC_TOP 6'h3e
`define OFF_W0 4'h0
`define OFF_W1 4'h4
`define OFF_W2 4'h8

// ----------------------------------------
// Address steps and reset values
// ----------------------------------------
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002
`define STEP_INC 2'h2
`define STEP_DEC 2'h3
`define MODE_RST 8'h00
`define ADDR_RST 24'h000000
`define CNT_RST 16'h0000
`define SLOT_RST 6'h00

`endif

// ### include/xfer_pkg.sv
package xfer_pkg;

   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [3:0]
   {
      st_idle = 4'h0,
      st_rd0 = 4'h1,
      st_rd1 = 4'h2,
      st_rd2 = 4'h3,
      st_ld = 4'h4,
      st_xrd = 4'h5,
      st_xwr = 4'h6,
      st_upd = 4'h7,
      st_wb0 = 4'h8,
      st_wb1 = 4'h9,
      st_wb2 = 4'ha
   } state_e;

   // ----------------------------------------
   // Transfer modes and mode word layout
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      xm_normal = 2'h0,
      xm_repeat = 2'h1,
      xm_block = 2'h2,
      xm_rsvd = 2'h3
   } xmode_e;

   // Bit 7 down to bit 0 of the mode word
   typedef struct packed
   {
      logic [1:0] src_step;
      logic [1:0] dest_step;
      xmode_e mode;
      logic area_side_select;
      logic unit_size_bit;
   } mode_s;

   // ----------------------------------------
   // Bus request carriers
   // ----------------------------------------
   typedef struct packed
   {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic rd;
      logic wr;
   } desc_req_s;

   typedef struct packed
   {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic word;
      logic rd;
      logic wr;
   } data_req_s;

endpackage

// ### src/transfer_descriptor_engine.sv
// How it works
// - Mode word size bit picks byte transfers when clear, word when set.
// - Side-select clear makes destination the area, set makes source it.
// - Two-bit mode field selects normal, repeat or block transfer mode.
// - Destination increment adds one or two per transfer; fixed holds.
// - Destination decrement subtracts one or two per transfer.
// - Source increment adds one or two per transfer; fixed holds.
// - Source decrement subtracts one or two per transfer.
// - Writes go to the 24-bit destination pointer from the descriptor.
// - Reads come from the source pointer held in the descriptor.
// - Transfer count A sets how many data transfers are done in normal mode.
// - Block count B sets how many blocks run in block mode.
// - Descriptors live in on-chip RAM, reached over a 32-bit path.
// - Descriptors are fetched only from F800 to FBFF.
`include "xfer_params.svh"

module transfer_descriptor_engine (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic act_req,
   output xfer_pkg::desc_req_s desc_req,
   input wire logic [31:0] desc_rdata,
   output xfer_pkg::data_req_s data_req,
   input wire logic [15:0] data_rdata,
   input wire logic data_ack,
   output logic busy
);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Address arithmetic
   // ----------------------------------------
   // One step of a pointer after a transfer
   function automatic logic [23:0] step_addr(input logic [23:0] a,
      input logic [1:0] m, input logic sz);
      logic [23:0] d;
      d = sz ? `STEP_WORD : `STEP_BYTE;
      return (m == `STEP_INC) ? a - (-d) :
         (m == `STEP_DEC) ? a - d : a;
   endfunction

   // Undo a whole area of steps; a size of zero means 256 units
   function automatic logic [23:0] unwind(input logic [23:0] a,
      input logic [1:0] m, input logic sz, input logic [7:0] cnt);
      logic [23:0] d;
      d = sz ? {14'h0000, cnt == 8'h00, cnt, 1'b0} :
         {15'h0000, cnt == 8'h00, cnt};
      return (m == `STEP_INC) ? a - d :
         (m == `STEP_DEC) ? a + d : a;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   xfer_pkg::state_e state_q, state_d;
   xfer_pkg::mode_s mode_q;
   logic [23:0] src_q, dst_q;
   logic [7:0] aux_q;
   logic [15:0] cnta_q, cntb_q, data_q;
   logic [5:0] slot_q, idx_q;
   logic done_q, end_q, fin_q;
   logic [31:0] rdata_q;

   // ----------------------------------------
   // Register port decode
   // ----------------------------------------
   // Start is ignored while a run is active; no queueing of requests
   wire logic ctrl_wr = reg_wr && (reg_addr == `REG_CTRL);
   wire logic stat_wr = reg_wr && (reg_addr == `REG_STAT);
   wire logic sw_start = ctrl_wr && reg_wdata[`CTRL_START];
   wire logic idle = (state_q == xfer_pkg::st_idle);
   wire logic start = idle && (sw_start || act_req);
   wire logic [5:0] start_idx = ctrl_wr ? reg_wdata[13:8] : slot_q;
   wire logic [31:0] stat_w = {29'h00000000, end_q, done_q, busy};
   wire logic [31:0] ctrl_w = {18'h00000, slot_q, 8'h00};
   wire logic [31:0] rd_mux = (reg_addr == `REG_CTRL) ? ctrl_w :
      (reg_addr == `REG_STAT) ? stat_w : 32'h00000000;

   // ----------------------------------------
   // Mode decode and next field values
   // ----------------------------------------
   wire logic is_block = (mode_q.mode == xfer_pkg::xm_block);
   wire logic is_rep = (mode_q.mode == xfer_pkg::xm_repeat);
   wire logic is_norm = !(is_block || is_rep);
   wire logic area_src = !is_norm && mode_q.area_side_select;
   wire logic area_dst = !is_norm && !mode_q.area_side_select;
   wire logic [7:0] lo_dec = cnta_q[7:0] - 8'h01;
   wire logic wrap = !is_norm && (lo_dec == 8'h00);
   wire logic [15:0] cntb_dec = cntb_q - 16'h0001;
   wire logic more = is_block && !wrap;
   wire logic [23:0] src_st = step_addr(src_q, mode_q.src_step,
      mode_q.unit_size_bit);
   wire logic [23:0] dst_st = step_addr(dst_q, mode_q.dest_step,
      mode_q.unit_size_bit);
   wire logic [23:0] src_nx = (wrap && area_src) ? unwind(src_st,
      mode_q.src_step, mode_q.unit_size_bit, cnta_q[15:8]) : src_st;
   wire logic [23:0] dst_nx = (wrap && area_dst) ? unwind(dst_st,
      mode_q.dest_step, mode_q.unit_size_bit, cnta_q[15:8]) : dst_st;
   // Normal mode counts all 16 bits; the others reload the low byte
   wire logic [15:0] cnta_nx = is_norm ? cnta_q - 16'h0001 :
      {cnta_q[15:8], wrap ? cnta_q[15:8] : lo_dec};
   wire logic seq_end = is_norm ? (cnta_q == 16'h0001) :
      (is_block && wrap && (cntb_dec == 16'h0000));

   // ----------------------------------------
   // Descriptor port
   // ----------------------------------------
   // Slots are 16 bytes apart so the area holds 64 descriptors
   wire logic [3:0] off = (state_q == xfer_pkg::st_rd1 ||
      state_q == xfer_pkg::st_wb1) ? `OFF_W1 :
      (state_q == xfer_pkg::st_rd2 || state_q == xfer_pkg::st_wb2) ?
      `OFF_W2 : `OFF_W0;
   wire logic d_rd = (state_q == xfer_pkg::st_rd0) ||
      (state_q == xfer_pkg::st_rd1) || (state_q == xfer_pkg::st_rd2);
   wire logic d_wr = (state_q == xfer_pkg::st_wb0) ||
      (state_q == xfer_pkg::st_wb1) || (state_q == xfer_pkg::st_wb2);
   wire logic [31:0] d_wdata = (state_q == xfer_pkg::st_wb0) ?
      {mode_q, src_q} : (state_q == xfer_pkg::st_wb1) ?
      {aux_q, dst_q} : {cnta_q, cntb_q};
   assign desc_req = '{addr: {`DESC_TOP, idx_q, off},
      wdata: d_wdata, rd: d_rd, wr: d_wr};

   // ----------------------------------------
   // Data bus port
   // ----------------------------------------
   assign data_req = '{
      addr: (state_q == xfer_pkg::st_xrd) ? src_q : dst_q,
      wdata: data_q,
      word: mode_q.unit_size_bit,
      rd: state_q == xfer_pkg::st_xrd,
      wr: state_q == xfer_pkg::st_xwr};
   assign busy = !idle;
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Each activation: fetch, transfer (a block in block mode), write back
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         xfer_pkg::st_idle: state_d = start ? xfer_pkg::st_rd0 : state_q;
         xfer_pkg::st_rd0: state_d = xfer_pkg::st_rd1;
         xfer_pkg::st_rd1: state_d = xfer_pkg::st_rd2;
         xfer_pkg::st_rd2: state_d = xfer_pkg::st_ld;
         xfer_pkg::st_ld: state_d = xfer_pkg::st_xrd;
         xfer_pkg::st_xrd: state_d = data_ack ? xfer_pkg::st_xwr : state_q;
         xfer_pkg::st_xwr: state_d = data_ack ? xfer_pkg::st_upd : state_q;
         xfer_pkg::st_upd: state_d = more ? xfer_pkg::st_xrd :
            xfer_pkg::st_wb0;
         xfer_pkg::st_wb0: state_d = xfer_pkg::st_wb1;
         xfer_pkg::st_wb1: state_d = xfer_pkg::st_wb2;
         xfer_pkg::st_wb2: state_d = xfer_pkg::st_idle;
         default: state_d = xfer_pkg::st_idle;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         state_q <= xfer_pkg::st_idle;
      else
         state_q <= state_d;
   end

   // ----------------------------------------
   // Descriptor fields
   // ----------------------------------------
   // Fields are loaded over the 32-bit path; reset values are only for
   // clean outputs, software must fill every field of a slot before its start
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mode_q <= xfer_pkg::mode_s'(`MODE_RST);
         src_q <= `ADDR_RST;
         dst_q <= `ADDR_RST;
         aux_q <= 8'h00;
         cnta_q <= `CNT_RST;
         cntb_q <= `CNT_RST;
      end
      else if (state_q == xfer_pkg::st_rd1)
      begin
         mode_q <= xfer_pkg::mode_s'(desc_rdata[31:24]);
         src_q <= desc_rdata[23:0];
      end
      else if (state_q == xfer_pkg::st_rd2)
      begin
         aux_q <= desc_rdata[31:24];
         dst_q <= desc_rdata[23:0];
      end
      else if (state_q == xfer_pkg::st_ld)
      begin
         cnta_q <= desc_rdata[31:16];
         cntb_q <= desc_rdata[15:0];
      end
      else if (state_q == xfer_pkg::st_upd)
      begin
         src_q <= src_nx;
         dst_q <= dst_nx;
         cnta_q <= cnta_nx;
         cntb_q <= (is_block && wrap) ? cntb_dec : cntb_q;
      end
   end

   // Read data latch; bytes sit in the low lane
   always_ff @(posedge mclk)
   begin
      if (rst)
         data_q <= 16'h0000;
      else if (data_req.rd && data_ack)
         data_q <= mode_q.unit_size_bit ? data_rdata :
            {8'h00, data_rdata[7:0]};
   end

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   // A set in the same cycle as a write-one clear wins over it
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         slot_q <= `SLOT_RST;
         idx_q <= `SLOT_RST;
         done_q <= 1'b0;
         end_q <= 1'b0;
         fin_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         slot_q <= ctrl_wr ? reg_wdata[13:8] : slot_q;
         idx_q <= start ? start_idx : idx_q;
         fin_q <= start ? 1'b0 :
            (state_q == xfer_pkg::st_upd) ? seq_end : fin_q;
         done_q <= (state_q == xfer_pkg::st_wb2) ||
            (done_q && !(stat_wr && reg_wdata[`STAT_DONE]));
         end_q <= (state_q == xfer_pkg::st_wb2 && fin_q) ||
            (end_q && !(stat_wr && reg_wdata[`STAT_END]));
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   wire logic upd = (state_q == xfer_pkg::st_upd);
   wire logic [23:0] unit = mode_q.unit_size_bit ? `STEP_WORD : `STEP_BYTE;

   // A finished read hands its lane-adjusted data to the write
   a_size_lane: assert property (
      data_req.rd && data_ack |=> data_req.wr &&
      data_req.wdata == (mode_q.unit_size_bit ? $past(data_rdata) :
      {8'h00, $past(data_rdata[7:0])}))
      else $error("transfer width does not follow size bit");
   a_area_side: assert property (
      upd && wrap && !mode_q.area_side_select &&
      mode_q.src_step == `STEP_INC |=> src_q == $past(src_q) + $past(unit))
      else $error("source moved back although destination is area");
   a_mode_single: assert property (
      upd && !is_block |=> state_q == xfer_pkg::st_wb0 ##3 idle)
      else $error("normal or repeat run did more than one transfer");
   a_dst_inc: assert property (
      upd && !wrap && mode_q.dest_step == `STEP_INC |=>
      dst_q == $past(dst_q) + $past(unit))
      else $error("destination increment wrong");
   a_dst_dec: assert property (
      upd && !wrap && mode_q.dest_step == `STEP_DEC |=>
      dst_q == $past(dst_q) - $past(unit))
      else $error("destination decrement wrong");
   a_src_inc: assert property (
      upd && !wrap && mode_q.src_step == `STEP_INC |=>
      src_q == $past(src_q) + $past(unit))
      else $error("source increment wrong");
   a_src_fixed: assert property (
      upd && mode_q.src_step[1] == 1'b0 |=> $stable(src_q))
      else $error("fixed source pointer moved");
   a_src_dec: assert property (
      upd && !wrap && mode_q.src_step == `STEP_DEC |=>
      src_q == $past(src_q) - $past(unit))
      else $error("source decrement wrong");
   // A waiting request keeps its address until the far side answers
   a_dst_addr: assert property (
      data_req.wr && !data_ack |=> data_req.wr && $stable(data_req.addr))
      else $error("write not held at destination pointer");
   a_src_addr: assert property (
      data_req.rd && !data_ack |=> data_req.rd && $stable(data_req.addr))
      else $error("read not held at source pointer");
   a_count_a: assert property (
      upd && is_norm |=> cnta_q == $past(cnta_q) - 16'h0001)
      else $error("count A not decremented");
   a_count_b: assert property (
      upd && is_block && wrap |=>
      cntb_q == $past(cntb_q) - 16'h0001 ##3 idle)
      else $error("block count not decremented at block end");
   a_desc_path: assert property (
      state_q == xfer_pkg::st_ld |=> {cnta_q, cntb_q} == $past(desc_rdata))
      else $error("count word not taken whole");
   a_desc_range: assert property (
      desc_req.rd || desc_req.wr |->
      desc_req.addr >= `DESC_LO && desc_req.addr <= `DESC_HI)
      else $error("descriptor access outside its area");
   a_writeback: assert property (
      state_q == xfer_pkg::st_wb2 |->
      desc_req.wr && desc_req.wdata == {cnta_q, cntb_q} ##1 done_q)
      else $error("counts not written back");

   c_normal_end: cover property (state_q == xfer_pkg::st_wb2 && fin_q &&
      is_norm);
   c_block_loop: cover property (upd && more ##[1:20] upd && wrap);
   c_repeat_wrap: cover property (upd && is_rep && wrap);

endmodule

// ### test/mem_model.sv
// ----------------------------------------
// Descriptor RAM and data-side memory model
// ----------------------------------------
module mem_model (
   input wire logic mclk,
   input wire logic rst,
   input wire xfer_pkg::desc_req_s desc_req,
   output logic [31:0] desc_rdata,
   input wire xfer_pkg::data_req_s data_req,
   output logic [15:0] data_rdata,
   output logic data_ack,
   input wire logic [3:0] lat
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [31:0] desc_q [256];
   logic [40:0] wlog [$];
   int bad_cnt = 0;
   logic [3:0] wait_q;
   logic [15:0] rd_val;
   wire logic [7:0] idx = desc_req.addr[9:2];
   wire logic busy_bus = data_req.rd | data_req.wr;

   // Source data is a pattern of the address, so reads are predictable
   assign rd_val = {data_req.addr[7:0] ^ 8'ha5, data_req.addr[7:0]};
   // Ack after lat wait cycles; lat 0 answers in the request cycle
   assign data_ack = busy_bus && (wait_q == lat);
   // An idle lane shows the inverse, never a stale copy of the answer
   assign data_rdata = data_ack ? rd_val : ~rd_val;

   // Wait counter, 32-bit descriptor port and write log
   always @(posedge mclk)
   begin
      if (rst || data_ack || !busy_bus)
         wait_q <= 4'h0;
      else
         wait_q <= wait_q + 4'h1;
      if ((desc_req.rd || desc_req.wr) &&
          (desc_req.addr < 16'hf800 || desc_req.addr > 16'hfbff))
         bad_cnt++;
      if (rst)
         desc_rdata <= 32'h0;
      else if (desc_req.rd)
         desc_rdata <= desc_q[idx];
      else
         desc_rdata <= ~desc_rdata;
      if (desc_req.wr)
         desc_q[idx] <= desc_req.wdata;
      if (data_req.wr && data_ack)
         wlog.push_back({data_req.word, data_req.addr, data_req.wdata});
   end
endmodule

// ### test/tb.sv
`include "xfer_params.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed
   {
      logic [7:0] mode;
      logic [23:0] src;
      logic [23:0] dst;
      logic [15:0] cnta;
      logic [3:0] lat;
      logic [23:0] src_x;
      logic [23:0] dst_x;
      logic [15:0] cnt_x;
      logic [15:0] data_x;
      logic end_x;
   } row_s;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic act_req = 1'b0;
   logic [3:0] lat = 4'h0;
   logic [31:0] reg_rdata;
   logic [31:0] desc_rdata;
   logic [15:0] data_rdata;
   logic data_ack;
   logic busy;
   xfer_pkg::desc_req_s desc_req;
   xfer_pkg::data_req_s data_req;
   int fail_count = 0;
   int cmp_count = 0;
   int s;
   row_s r;
   logic [31:0] d;
   // Normal mode rows: every step mode, both sizes, carries, count ends;
   // each row ends in the pointers, count, data and end flag it must give
   row_s rows [6] = '{
      '{8'h00, 24'h001230, 24'h004560, 16'h0005, 4'h0, 24'h001230,
         24'h004560, 16'h0004, 16'h0030, 1'b0},
      '{8'ha0, 24'h0010ff, 24'h0020ff, 16'h0003, 4'h2, 24'h001100,
         24'h002100, 16'h0002, 16'h00ff, 1'b0},
      '{8'hf1, 24'h010000, 24'h020000, 16'h0001, 4'h1, 24'h00fffe,
         24'h01fffe, 16'h0000, 16'ha500, 1'b1},
      '{8'h61, 24'h00abcd, 24'h003000, 16'h0002, 4'h0, 24'h00abcd,
         24'h003002, 16'h0001, 16'h68cd, 1'b0},
      '{8'h90, 24'hfffffe, 24'h000001, 16'h0000, 4'h3, 24'hffffff,
         24'h000001, 16'hffff, 16'h00fe, 1'b0},
      '{8'h0d, 24'h000040, 24'h000050, 16'h0002, 4'h0, 24'h000040,
         24'h000050, 16'h0001, 16'he540, 1'b0}};

   transfer_descriptor_engine dut_u (.mclk(mclk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_req(act_req),
      .desc_req(desc_req), .desc_rdata(desc_rdata), .data_req(data_req),
      .data_rdata(data_rdata), .data_ack(data_ack), .busy(busy));

   mem_model mem_u (.mclk(mclk), .rst(rst), .desc_req(desc_req),
      .desc_rdata(desc_rdata), .data_req(data_req),
      .data_rdata(data_rdata), .data_ack(data_ack), .lat(lat));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial
   begin
      forever #4 mclk = ~mclk;
   end

   // Byte transfers carry a zero upper lane
   function automatic logic [15:0] pat(logic [23:0] a, logic z);
      return {z ? a[7:0] ^ 8'ha5 : 8'h00, a[7:0]};
   endfunction

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic reg_write(logic [7:0] a, logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Software fills every field first; reset leaves them undefined
   task automatic preload(int n, logic [7:0] m, logic [23:0] sa,
                          logic [23:0] da, logic [31:0] w2);
      mem_u.desc_q[n * 4] = {m, sa};
      mem_u.desc_q[n * 4 + 1] = {8'h00, da};
      mem_u.desc_q[n * 4 + 2] = w2;
   endtask

   task automatic start(int n);
      reg_write(`REG_CTRL, {18'h0, n[5:0], 8'h01});
   endtask

   // Bounded wait for the activation to return to idle
   task automatic wdone();
      int i;
      i = 0;
      do
      begin
         @(posedge mclk);
         #1 i++;
      end
      while (busy !== 1'b0 && i < 500);
      chk("busy end", 32'h0, {31'h0, busy});
   endtask

   task automatic chk_wr(logic [23:0] a, logic [15:0] v, logic w);
      logic [40:0] e;
      e = (mem_u.wlog.size() > 0) ? mem_u.wlog.pop_front() : '1;
      chk("wr addr", {8'h00, a}, {8'h00, e[39:16]});
      chk("wr data", {16'h0, v}, {16'h0, e[15:0]});
      chk("wr word", {31'h0, w}, {31'h0, e[40]});
   endtask

   task automatic chk_desc(int n, logic [31:0] w0, logic [23:0] da,
                           logic [31:0] w2, logic [31:0] st);
      chk("src wb", w0, mem_u.desc_q[n * 4]);
      chk("dst wb", {8'h00, da}, {8'h00, mem_u.desc_q[n * 4 + 1][23:0]});
      chk("cnt wb", w2, mem_u.desc_q[n * 4 + 2]);
      chk("extra wr", 32'h0, 32'(mem_u.wlog.size()));
      reg_read(`REG_STAT, d);
      chk("stat", st, d);
      reg_write(`REG_STAT, 32'h6);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #200000;
      fail_count++;
      final_report();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1 chk("rst busy", 32'h0, {31'h0, busy});
      chk("rst desc", 32'hf800, {16'h0, desc_req.addr});
      chk("rst data", 32'h0, {29'h0, data_req.word, data_req.rd,
          data_req.wr});
      reg_read(`REG_STAT, d);
      chk("rst stat", 32'h0, d);
      foreach (rows[k])
      begin
         r = rows[k];
         s = k + 1;
         preload(s, r.mode, r.src, r.dst, {r.cnta, 16'h0007});
         @(posedge mclk);
         lat <= r.lat;
         start(s);
         wdone();
         chk_wr(r.dst, r.data_x, r.mode[0]);
         chk_desc(s, {r.mode, r.src_x}, r.dst_x,
                  {r.cnt_x, 16'h0007},
                  {29'h0, r.end_x, 2'b10});
      end
      // Block mode, destination area: one block of two, then it ends
      preload(10, 8'ha8, 24'h000100, 24'h000200, 32'h02020001);
      start(10);
      wdone();
      chk_wr(24'h000200, pat(24'h000100, 1'b0), 1'b0);
      chk_wr(24'h000201, pat(24'h000101, 1'b0), 1'b0);
      chk_desc(10, 32'ha8000102, 24'h000200, 32'h02020000,
               32'h6);
      // Repeat mode, source area: source pointer wraps back
      preload(11, 8'ha6, 24'h000300, 24'h000400, 32'h01010009);
      start(11);
      wdone();
      chk_wr(24'h000400, pat(24'h000300, 1'b0), 1'b0);
      chk_desc(11, 32'ha6000300, 24'h000401, 32'h01010009, 32'h2);
      // Starts while busy are refused, but the slot index is kept
      preload(20, 8'h00, 24'h000500, 24'h000600, 32'h00050000);
      preload(21, 8'h00, 24'h000510, 24'h000700, 32'h00030000);
      @(posedge mclk);
      lat <= 4'h8;
      start(20);
      start(21);
      @(posedge mclk);
      act_req <= 1'b1;
      @(posedge mclk);
      act_req <= 1'b0;
      wdone();
      chk_wr(24'h000600, pat(24'h000500, 1'b0), 1'b0);
      chk_desc(20, 32'h00000500, 24'h000600, 32'h00040000, 32'h2);
      @(posedge mclk);
      act_req <= 1'b1;
      @(posedge mclk);
      act_req <= 1'b0;
      wdone();
      chk_wr(24'h000700, pat(24'h000510, 1'b0), 1'b0);
      chk_desc(21, 32'h00000510, 24'h000700, 32'h00020000, 32'h2);
      reg_read(`REG_CTRL, d);
      chk("ctrl", 32'h00001500, d);
      reg_write(8'h08, 32'hffffffff);
      reg_read(8'h08, d);
      chk("unmapped", 32'h0, d);
      // Reset in mid-transfer: the engine idles and nothing is written back
      preload(22, 8'h00, 24'h000800, 24'h000900, 32'h00060000);
      start(22);
      repeat (6) @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1 chk("mid rst busy", 32'h0, {31'h0, busy});
      chk("mid rst req", 32'h0, {30'h0, data_req.rd, data_req.wr});
      chk("mid rst cnt", 32'h00060000, mem_u.desc_q[22 * 4 + 2]);
      chk("mid rst wr", 32'h0, 32'(mem_u.wlog.size()));
      reg_read(`REG_STAT, d);
      chk("mid rst stat", 32'h0, d);
      chk("desc range", 32'h0, 32'(mem_u.bad_cnt));
      final_report();
   end
endmodule
